// ===== verilog/cse_exec.sv
// cse_exec: decode and execute compare-and-skip instructions by phase
// assumes the fetch unit presents each word and the next word's two-word flag at q1
// Function
// RQ1 - pattern 0110 001a decodes as compare_skip_equal, skip on equality
// RQ2 - pattern 0110 010a decodes as compare_skip_greater, unsigned
// RQ3 - pattern 0110 000a decodes as compare_skip_less, unsigned
// RQ4 - unsigned subtraction, result discarded, no status flag changes
// RQ5 - on skip, fetched instruction dropped, one no-operation cycle added
// RQ6 - skipping a two-word instruction costs three cycles in total
// RQ7 - skip cycles do no read, no processing, no write
// RQ8 - access bit clear picks access bank, set picks bank_select_register
// RQ9 - program counter lands past one or past two instructions
// RQ10 - normal phases: decode, read file, process, idle fourth phase
`timescale 1ns/1ps
module cse_exec
  import cse_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_is_two_word,
  input  wire logic        working_register_load,
  input  wire logic [7:0]  working_register_data,
  input  wire logic        bsr_load,
  input  wire logic [3:0]  bsr_data,
  input  wire logic [7:0]  mem_rd_data,
  output logic             mem_rd_en,
  output logic [11:0]      mem_rd_addr,
  output logic             mem_wr_en,
  output logic             status_wr_en,
  output logic             nop_cycle,
  output logic             instr_busy,
  output logic [20:0]      pc,
  output cse_pkg::cse_phase_t phase
);
  import cse_pkg::*;

  cse_dmem_if mem ();
  cse_phase_t phase_reg;
  cse_op_t    op_reg;
  logic [7:0] working_register;
  logic [3:0] bank_select_register;
  logic [1:0] skip_left_reg;
  logic [7:0] faddr_reg;
  logic       acc_reg;
  logic       two_word_reg;
  logic       skip_cond;
  logic       rd_en_reg;
  logic [11:0] rd_addr_reg;
  logic [20:0] pc_reg;
  cse_op_t    op_next;

  assign mem.rd_data = mem_rd_data;
  assign mem.rd_en   = rd_en_reg;
  assign mem.rd_addr = rd_addr_reg;
  assign mem_rd_en   = mem.rd_en;
  assign mem_rd_addr = mem.rd_addr;
  // RQ4 no write and no status update
  assign mem_wr_en    = 1'b0;
  assign status_wr_en = 1'b0;
  assign nop_cycle    = (skip_left_reg != 2'd0);
  assign instr_busy   = (op_reg != CSE_OP_NONE) || nop_cycle;
  assign pc           = pc_reg;
  assign phase        = phase_reg;

  always_comb
  begin
    unique case (instr_word[OPC_HI:OPC_LO])
      OPC_SKIP_EQUAL: op_next = CSE_OP_EQ;
      OPC_SKIP_GRTR:  op_next = CSE_OP_GT;
      OPC_SKIP_LESS:  op_next = CSE_OP_LT;
      default:        op_next = CSE_OP_NONE;
    endcase
  end

  cse_compare u_cmp (
    .mem              (mem.cmp),
    .working_register (working_register),
    .op               (op_reg),
    .skip_cond        (skip_cond)
  );

  // phase counter
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      phase_reg <= CSE_Q1;
    else
      phase_reg <= cse_phase_t'(phase_reg + 2'd1);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      working_register <= WORKING_REGISTER_RESET;
    else if (working_register_load)
      working_register <= working_register_data;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      bank_select_register <= BSR_RESET;
    else if (bsr_load)
      bank_select_register <= bsr_data;
  end

  // RQ10 q1 decode, latched only outside skip cycles
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_reg       <= CSE_OP_NONE;
      faddr_reg    <= 8'h00;
      acc_reg      <= 1'b0;
      two_word_reg <= 1'b0;
    end
    else if (phase_reg == CSE_Q1 && skip_left_reg == 2'd0)
    begin
      op_reg       <= op_next;
      faddr_reg    <= instr_word[7:0];
      acc_reg      <= instr_word[ACC_BIT];
      two_word_reg <= next_is_two_word;
    end
    else if (phase_reg == CSE_Q4)
      op_reg <= CSE_OP_NONE;
  end

  // RQ8 bank selection on q2 read
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_en_reg   <= 1'b0;
      rd_addr_reg <= 12'h000;
    end
    else
    begin
      // RQ10 read issued at end of q2, data used in q3
      // op_reg only holds the new compare once the q1 edge has passed
      rd_en_reg <= (phase_reg == CSE_Q2) && (op_reg != CSE_OP_NONE)
                   && (skip_left_reg == 2'd0);
      if (phase_reg == CSE_Q2)
        rd_addr_reg <= {acc_reg ? bank_select_register : ACCESS_BANK,
                        faddr_reg};
    end
  end

  // RQ5 skip cycles counted at q3 result
  // RQ6 two nop cycles for a two-word target
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      skip_left_reg <= 2'd0;
    else if (phase_reg == CSE_Q3 && op_reg != CSE_OP_NONE && skip_cond)
      skip_left_reg <= two_word_reg ? 2'd2 : 2'd1;
    else if (phase_reg == CSE_Q4 && skip_left_reg != 2'd0
             && op_reg == CSE_OP_NONE)
      skip_left_reg <= skip_left_reg - 2'd1;
  end

  // RQ9 program counter advance per cycle, including skipped words
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pc_reg <= PC_RESET;
    else if (phase_reg == CSE_Q4)
      pc_reg <= pc_reg + PC_WORD;
  end

  // RQ7 skip cycles never read memory
  no_read_skip_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (nop_cycle && op_reg == CSE_OP_NONE) |-> !mem_rd_en)
    else $error("memory read during skip cycle");

  // RQ4 never any write
  no_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !mem_wr_en && !status_wr_en)
    else $error("write seen from compare");

  // RQ5 skip starts at q4 after true compare
  skip_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (phase_reg == CSE_Q3 && op_reg != CSE_OP_NONE && skip_cond)
    |=> nop_cycle)
    else $error("skip not entered");

  // RQ6 two-word skip lasts two more cycles
  skip_two_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (phase_reg == CSE_Q3 && op_reg != CSE_OP_NONE && skip_cond
     && two_word_reg) |=> ##5 nop_cycle)
    else $error("two-word skip too short");

  // RQ10 read issued at end of q2, enable seen only in q3
  read_q2_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    mem_rd_en |-> phase_reg == CSE_Q3)
    else $error("read outside q2 window");

  // RQ8 access bank when access bit clear
  bank_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mem_rd_en && !acc_reg) |-> mem_rd_addr[11:8] == ACCESS_BANK)
    else $error("wrong bank");

  // RQ9 pc steps one word per cycle
  pc_step_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    phase_reg == CSE_Q4 |=> pc_reg == $past(pc_reg) + PC_WORD)
    else $error("pc step wrong");

  // RQ1 equal compare decoded
  eq_decode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (phase_reg == CSE_Q1 && skip_left_reg == 2'd0
     && instr_word[OPC_HI:OPC_LO] == OPC_SKIP_EQUAL) |=> op_reg == CSE_OP_EQ)
    else $error("equal decode wrong");
endmodule

// ===== verilog/cse_pkg.sv
// cse_pkg: constants and types for the compare-and-skip execution unit
// assumes one core clock where four clocks make one instruction cycle
package cse_pkg;
  // opcode layout: bits 15:9 select the compare, bit 8 is the access bit
  localparam int         OPC_HI         = 15;
  localparam int         OPC_LO         = 9;
  localparam int         ACC_BIT        = 8;
  localparam logic [6:0] OPC_SKIP_LESS  = 7'h30;
  localparam logic [6:0] OPC_SKIP_EQUAL = 7'h31;
  localparam logic [6:0] OPC_SKIP_GRTR  = 7'h32;
  // access bank number used when the access bit is clear
  localparam logic [3:0] ACCESS_BANK    = 4'h0;
  localparam logic [7:0] WORKING_REGISTER_RESET     = 8'h00;
  localparam logic [3:0] BSR_RESET      = 4'h0;
  localparam logic [20:0] PC_RESET      = 21'h000000;
  // program counter step of one instruction word, in bytes
  localparam logic [20:0] PC_WORD       = 21'h000002;

  typedef enum logic [1:0] {CSE_Q1, CSE_Q2, CSE_Q3, CSE_Q4} cse_phase_t;
  typedef enum logic [1:0] {CSE_OP_NONE, CSE_OP_EQ, CSE_OP_GT,
                            CSE_OP_LT} cse_op_t;
endpackage

// ===== verilog/cse_dmem_if.sv
// cse_dmem_if: data memory read port between executor and comparator
// assumes the read data are valid in the same cycle as the request
`timescale 1ns/1ps
interface cse_dmem_if;
  logic       rd_en;
  logic [11:0] rd_addr;
  logic [7:0] rd_data;
  modport exec (output rd_en, output rd_addr, input rd_data);
  modport cmp  (input rd_data);
endinterface

// ===== verilog/cse_compare.sv
// cse_compare: unsigned subtraction of working register from data byte
// assumes operands are stable during the process phase
`timescale 1ns/1ps
module cse_compare
  import cse_pkg::*;
(
  cse_dmem_if.cmp      mem,
  input  wire logic [7:0]  working_register,
  input  wire cse_pkg::cse_op_t op,
  output logic             skip_cond
);
  logic [8:0] diff;

  // RQ4 subtraction result kept private
  assign diff = {1'b0, mem.rd_data} - {1'b0, working_register};

  always_comb
  begin
    unique case (op)
      // RQ1 equal test
      CSE_OP_EQ:   skip_cond = (diff == 9'h000);
      // RQ2 unsigned greater
      CSE_OP_GT:   skip_cond = !diff[8] && (diff != 9'h000);
      // RQ3 unsigned less via borrow
      CSE_OP_LT:   skip_cond = diff[8];
      CSE_OP_NONE: skip_cond = 1'b0;
    endcase
  end
endmodule

// ===== verif/compare_skip_execution_test.sv
// compare_skip_execution_test: self-checking bench for cse_exec
// assumes cse_pkg and the design modules are compiled beforehand
`timescale 1ns/1ps
module compare_skip_execution_test;
  import cse_pkg::*;
  logic        core_clk, rst_b, next_is_two_word, working_register_load, bsr_load;
  logic [15:0] instr_word;
  logic [7:0]  working_register_data, mem_rd_data, fbyte;
  logic [3:0]  bsr_data;
  logic        mem_rd_en, mem_wr_en, status_wr_en, nop_cycle, instr_busy;
  logic [11:0] mem_rd_addr, exp_addr;
  logic [20:0] pc;
  cse_phase_t  phase;
  logic [31:0] seed = 32'h6a56;
  int          error_cnt = 0;
  int          tests_run = 0;

  cse_exec DUT (.core_clk(core_clk), .rst_b(rst_b), .instr_word(instr_word),
    .next_is_two_word(next_is_two_word), .working_register_load(working_register_load),
    .working_register_data(working_register_data), .bsr_load(bsr_load), .bsr_data(bsr_data),
    .mem_rd_data(mem_rd_data), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_wr_en(mem_wr_en),
    .status_wr_en(status_wr_en), .nop_cycle(nop_cycle),
    .instr_busy(instr_busy), .pc(pc), .phase(phase));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic exp_skip(logic [6:0] op, logic [7:0] f, w);
    if (op == OPC_SKIP_EQUAL)
      return f == w;
    if (op == OPC_SKIP_GRTR)
      return f > w;
    return f < w;
  endfunction

  task automatic check(string nm, logic [20:0] e, logic [20:0] g);
    tests_run++;
    if (e !== g)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task give_verdict;
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one compare, then follow it until the next accepted word
  task automatic run_cmp(logic [6:0] op, logic a, logic [7:0] f, w,
                         logic [3:0] b, logic two);
    int n, nopn, rdn, busyn;
    logic [20:0] p0;
    logic [1:0]  skw;
    @(negedge core_clk);
    working_register_load = 1'b1;
    working_register_data = w;
    bsr_load  = 1'b1;
    bsr_data  = b;
    @(negedge core_clk);
    working_register_load = 1'b0;
    bsr_load  = 1'b0;
    n = 0;
    while (!(phase === CSE_Q1 && nop_cycle === 1'b0) && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    instr_word = {op, a, f};
    next_is_two_word = two;
    exp_addr = {a ? b : ACCESS_BANK, f};
    fbyte = f;
    p0 = pc;
    nopn = 0;
    rdn = 0;
    busyn = 0;
    skw = exp_skip(op, f, w) ? (two ? 2'd2 : 2'd1) : 2'd0;
    for (n = 0; n < 20; n++)
    begin
      @(negedge core_clk);
      nopn += nop_cycle;
      rdn += mem_rd_en;
      busyn += instr_busy;
      if (phase === CSE_Q1 && nop_cycle === 1'b0)
        break;
      // compare word offered while skipping must be ignored
      instr_word = {OPC_SKIP_EQUAL, 1'b1, 8'h5a};
    end
    instr_word = 16'h0000;
    next_is_two_word = 1'b0;
    // skip flag already rises in q4 of the compare itself
    check("nop cycles", (skw == 2'd0) ? 21'd0 : 21'(4 * skw + 1),
          21'(nopn));
    check("busy cycles", 21'(3 + 4 * skw), 21'(busyn));
    check("cycle count", 21'(4 * (1 + skw)), 21'(n + 1));
    check("pc step", p0 + PC_WORD * (21'd1 + 21'(skw)), pc);
    check("read count", 21'd1, 21'(rdn));
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // invariants and data memory responder
  always @(negedge core_clk)
  begin
    mem_rd_data = mem_rd_en ? fbyte : ~fbyte;
    if (rst_b)
    begin
      check("mem write", 21'd0, 21'(mem_wr_en));
      check("status write", 21'd0, 21'(status_wr_en));
      if (nop_cycle === 1'b1)
        check("read in skip", 21'd0, 21'(mem_rd_en));
      if (mem_rd_en === 1'b1)
        check("read address", 21'(exp_addr), 21'(mem_rd_addr));
    end
  end

  initial
  begin
    #50000;
    error_cnt++;
    give_verdict;
  end

  initial
  begin
    logic [6:0] ops[3];
    logic [31:0] r;
    ops = '{OPC_SKIP_LESS, OPC_SKIP_EQUAL, OPC_SKIP_GRTR};
    rst_b = 1'b0;
    instr_word = 16'h0000;
    next_is_two_word = 1'b0;
    {working_register_load, bsr_load, working_register_data, bsr_data} = '0;
    fbyte = 8'h00;
    mem_rd_data = 8'h00;
    exp_addr = 12'h000;
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    // boundary values for every compare kind
    for (int i = 0; i < 3; i++)
    begin
      run_cmp(ops[i], 1'b0, 8'h7f, 8'h7f, 4'h5, 1'b1);
      run_cmp(ops[i], 1'b1, 8'hff, 8'h00, 4'ha, 1'b0);
      run_cmp(ops[i], 1'b1, 8'h00, 8'hff, 4'hf, 1'b1);
    end
    for (int i = 0; i < 40; i++)
    begin
      r = rnd();
      run_cmp(ops[r[1:0] % 3], r[2], r[15:8], i[3] ? r[15:8] : r[23:16],
              r[27:24], r[3]);
    end
    give_verdict;
  end
endmodule
